// >>> core/csrc_core.sv
`timescale 1ns/100ps
`default_nettype none

module csrc_core
    import csrc_pkg::*;
#(
    parameter int unsigned REF_SETTLE_CYC = CSRC_REF_SETTLE_CYC
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   ce_i,
    input  wire logic                   link_sclk_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   din_i,
    output logic                        conv_stb_o,
    output csrc_conv_s                  conv_cfg_o,
    output logic [CSRC_SPAN_W-1:0]      input_span_config_o,
    output csrc_span_e                  chan0_span_o,
    output csrc_span_e                  chan1_span_o,
    output logic [CSRC_CTL_W-1:0]       ctl_word_o,
    output logic                        channel_select_bit_o,
    output logic                        sequence_active_o,
    output logic                        ref_internal_o,
    output logic                        ref_ready_o
);

    localparam int unsigned RW = $clog2(REF_SETTLE_CYC + 1);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (REF_SETTLE_CYC < 1) begin : g_bad_settle
        $error("REF_SETTLE_CYC must be at least one cycle.");
    end

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    logic [CSRC_SPAN_W-1:0] link_span_word;
    logic [CSRC_CTL_W-1:0]  link_ctl_word;
    logic                   link_span_tgl;
    logic                   link_ctl_tgl;

    csrc_link_rx u_link (
        .link_sclk_i (link_sclk_i),
        .sys_rst_i   (sys_rst_i),
        .cs_n_i      (cs_n_i),
        .din_i       (din_i),
        .span_word_o (link_span_word),
        .span_tgl_o  (link_span_tgl),
        .ctl_word_o  (link_ctl_word),
        .ctl_tgl_o   (link_ctl_tgl)
    );

    // ------------------------------------------------------------------
    // Crossing into the reference clock domain
    // ------------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic       span_evt;
    logic       ctl_evt;
    logic       conv_evt;

    // Bit 2 carries the frame pin, bits 1 and 0 the commit toggles.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 3'h4;
            sync2_q <= 3'h4;
            sync3_q <= 3'h4;
        end else if (ce_i) begin
            sync1_q <= {cs_n_i, link_ctl_tgl, link_span_tgl};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Toggle changes mark commits; a falling frame pin starts a conversion.
    assign span_evt = sync3_q[0] ^ sync2_q[0];
    assign ctl_evt  = sync3_q[1] ^ sync2_q[1];
    assign conv_evt = sync3_q[2] & ~sync2_q[2];

    // ------------------------------------------------------------------
    // Span and control registers
    // ------------------------------------------------------------------
    logic [CSRC_SPAN_W-1:0] span_q;
    logic [CSRC_CTL_W-1:0]  ctl_q;
    logic                   span_written_q;

    // The committed link word has been stable for several link edges.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            span_q         <= CSRC_SPAN_RST;
            span_written_q <= 1'b0;
        end else if (ce_i && span_evt) begin
            span_q         <= link_span_word;
            span_written_q <= 1'b1;
        end
    end

    // Control word; every bit powers up as 0, so the reference is external.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctl_q <= CSRC_CTL_RST;
        end else if (ce_i && ctl_evt) begin
            ctl_q <= link_ctl_word;
        end
    end

    logic seq_mode;
    logic seq_mode_new;
    logic final_chan;

    // Only the 10 pattern sequences; 00, 01 and 11 all select directly.
    assign seq_mode     = ctl_q[CSRC_CTL_SEQ_HI] & ~ctl_q[CSRC_CTL_SEQ_LO];
    assign seq_mode_new = link_ctl_word[CSRC_CTL_SEQ_HI]
                        & ~link_ctl_word[CSRC_CTL_SEQ_LO];
    assign final_chan   = ctl_q[CSRC_CTL_CHANNEL_SELECT_BIT];

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    csrc_seq_e seq_state_q;
    logic      seq_ptr_q;

    // A control write decides the state; a conversion advances the pointer.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seq_state_q <= CSRC_SEQ_OFF;
            seq_ptr_q   <= 1'b0;
        end else if (ce_i) begin
            unique case (seq_state_q)
                CSRC_SEQ_OFF: begin
                    if (ctl_evt && seq_mode_new) begin
                        seq_state_q <= CSRC_SEQ_RUN;
                        seq_ptr_q   <= 1'b0;
                    end
                end
                CSRC_SEQ_RUN: begin
                    if (ctl_evt && !seq_mode_new) begin
                        seq_state_q <= CSRC_SEQ_OFF;
                        seq_ptr_q   <= 1'b0;
                    end else if (conv_evt) begin
                        if (seq_ptr_q == final_chan) begin
                            seq_ptr_q <= 1'b0;
                        end else begin
                            seq_ptr_q <= seq_ptr_q + 1'b1;
                        end
                    end
                end
                default: begin
                    seq_state_q <= CSRC_SEQ_OFF;
                    seq_ptr_q   <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Internal reference settling
    // ------------------------------------------------------------------
    logic [RW-1:0] ref_cnt_q;

    // Counts from the enabling write; clearing the bit restarts the wait.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref_cnt_q <= '0;
        end else if (ce_i) begin
            if (!ctl_q[CSRC_CTL_REF]) begin
                ref_cnt_q <= '0;
            end else if (ref_cnt_q != RW'(REF_SETTLE_CYC)) begin
                ref_cnt_q <= ref_cnt_q + RW'(1);
            end
        end
    end

    assign ref_internal_o = ctl_q[CSRC_CTL_REF];
    assign ref_ready_o    = ctl_q[CSRC_CTL_REF]
                          && (ref_cnt_q == RW'(REF_SETTLE_CYC));

    // ------------------------------------------------------------------
    // Per-conversion configuration
    // ------------------------------------------------------------------
    logic       conv_chan;
    csrc_span_e conv_span;
    csrc_conv_s conv_q;
    logic       conv_stb_q;

    // Sequencing uses the pointer; otherwise the address bit decides.
    assign conv_chan = (seq_state_q == CSRC_SEQ_RUN) ? seq_ptr_q
                                                     : final_chan;
    // Each channel's stored span follows it into the conversion.
    assign conv_span = conv_chan
        ? csrc_span_e'(span_q[CSRC_SPAN_C1_HI:CSRC_SPAN_C1_LO])
        : csrc_span_e'(span_q[CSRC_SPAN_C0_HI:CSRC_SPAN_C0_LO]);

    // The result taken while the reference is still settling is flagged.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conv_q     <= '0;
            conv_stb_q <= 1'b0;
        end else if (ce_i) begin
            conv_stb_q <= conv_evt;
            if (conv_evt) begin
                conv_q.chan    <= conv_chan;
                conv_q.span    <= conv_span;
                conv_q.ref_int <= ctl_q[CSRC_CTL_REF];
                conv_q.ref_ok  <= !ctl_q[CSRC_CTL_REF]
                               || ref_ready_o;
            end
        end
    end

    assign conv_stb_o           = conv_stb_q;
    assign conv_cfg_o           = conv_q;
    assign input_span_config_o  = span_q;
    assign chan0_span_o = csrc_span_e'(span_q[CSRC_SPAN_C0_HI:
                                              CSRC_SPAN_C0_LO]);
    assign chan1_span_o = csrc_span_e'(span_q[CSRC_SPAN_C1_HI:
                                              CSRC_SPAN_C1_LO]);
    assign ctl_word_o           = ctl_q;
    assign channel_select_bit_o = final_chan;
    assign sequence_active_o    = (seq_state_q == CSRC_SEQ_RUN);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_frame_start;
        ce_i && conv_evt;
    endsequence

    sequence s_wrap_step;
        ce_i && conv_evt && !ctl_evt && sequence_active_o
            && (seq_ptr_q == final_chan);
    endsequence

    a_span_commit_load: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (ce_i && span_evt) |=> (span_q == $past(link_span_word)))
        else $error("Span register missed a committed span word.");

    a_span_power_default: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !span_written_q |-> (chan0_span_o == CSRC_SPAN_PM10
                             && chan1_span_o == CSRC_SPAN_PM10))
        else $error("Span left its default before any span write.");

    a_conv_strobe_follows: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        s_frame_start |=> conv_stb_o ##1 (!conv_stb_o || !$past(ce_i)))
        else $error("Conversion strobe not a single cycle after start.");

    a_conv_span_apply: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        s_frame_start |=> (conv_cfg_o.span == (conv_cfg_o.chan
            ? csrc_span_e'($past(span_q[CSRC_SPAN_C1_HI:CSRC_SPAN_C1_LO]))
            : csrc_span_e'($past(span_q[CSRC_SPAN_C0_HI:CSRC_SPAN_C0_LO])))))
        else $error("Conversion used a span not stored for its channel.");

    a_direct_chan_pick: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (s_frame_start and !sequence_active_o)
            |=> (conv_cfg_o.chan == $past(final_chan)))
        else $error("Direct mode did not convert the addressed channel.");

    a_seq_start_zero: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (ce_i && ctl_evt && seq_mode_new && !sequence_active_o)
            |=> (sequence_active_o && seq_ptr_q == 1'b0))
        else $error("Sequence did not start at channel 0.");

    a_seq_wrap_zero: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        s_wrap_step |=> (seq_ptr_q == 1'b0) && sequence_active_o)
        else $error("Sequence did not wrap after the final channel.");

    a_seq_exit_write: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (ce_i && ctl_evt && !seq_mode_new) |=> !sequence_active_o)
        else $error("Sequencing survived a write clearing the bits.");

    a_ref_settle_wait: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        $rose(ref_internal_o) |-> !ref_ready_o [*8])
        else $error("Reference reported ready too early.");

    a_ref_ok_flag: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (s_frame_start and ref_internal_o and !ref_ready_o)
            |=> !conv_cfg_o.ref_ok)
        else $error("Unsettled reference conversion marked usable.");

endmodule

`default_nettype wire

// >>> core/csrc_pkg.sv
`default_nettype none

package csrc_pkg;

    // ------------------------------------------------------------------
    // Serial frame layout, frame positions numbered 16 down to 1
    // ------------------------------------------------------------------
    localparam int unsigned CSRC_FRAME_BITS      = 16;
    localparam int unsigned CSRC_SPAN_EDGE       = 11;
    localparam int unsigned CSRC_CTL_EDGE        = 15;
    localparam int unsigned CSRC_POS_WRITE       = 16;
    localparam int unsigned CSRC_POS_ZERO        = 15;
    localparam int unsigned CSRC_POS_REGSEL      = 14;
    localparam int unsigned CSRC_POS_SPAN_TOP    = 13;
    localparam int unsigned CSRC_POS_SPAN_BOT    = 8;
    localparam int unsigned CSRC_POS_CTL_TOP     = 12;
    localparam int unsigned CSRC_POS_CTL_BOT     = 2;

    // ------------------------------------------------------------------
    // Register widths, fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CSRC_SPAN_W          = 6;
    localparam int unsigned CSRC_CTL_W           = 12;
    localparam int unsigned CSRC_SPAN_C0_HI      = 5;
    localparam int unsigned CSRC_SPAN_C0_LO      = 4;
    localparam int unsigned CSRC_SPAN_C1_HI      = 1;
    localparam int unsigned CSRC_SPAN_C1_LO      = 0;
    localparam int unsigned CSRC_CTL_CHANNEL_SELECT_BIT        = 10;
    localparam int unsigned CSRC_CTL_REF         = 4;
    localparam int unsigned CSRC_CTL_SEQ_HI      = 3;
    localparam int unsigned CSRC_CTL_SEQ_LO      = 2;
    localparam logic [5:0]  CSRC_SPAN_RST        = 6'h00;
    localparam logic [11:0] CSRC_CTL_RST         = 12'h000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CSRC_CLK_PERIOD_NS   = 40;
    localparam int unsigned CSRC_REF_SETTLE_NS   = 500000;
    localparam int unsigned CSRC_REF_SETTLE_CYC  =
        (CSRC_REF_SETTLE_NS + CSRC_CLK_PERIOD_NS - 1) / CSRC_CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CSRC_SPAN_PM10  = 2'h0,
        CSRC_SPAN_PM5   = 2'h1,
        CSRC_SPAN_PM2P5 = 2'h2,
        CSRC_SPAN_UNI10 = 2'h3
    } csrc_span_e;

    typedef enum logic [1:0] {
        CSRC_SEQ_OFF = 2'h0,
        CSRC_SEQ_RUN = 2'h1
    } csrc_seq_e;

    typedef struct packed {
        logic       chan;
        csrc_span_e span;
        logic       ref_int;
        logic       ref_ok;
    } csrc_conv_s;

endpackage

`default_nettype wire

// >>> core/csrc_link_rx.sv
`timescale 1ns/100ps
`default_nettype none

// Link-side frame receiver: shifts the serial line in on falling link
// clock edges and commits span and control words with a toggle each.
module csrc_link_rx
    import csrc_pkg::*;
(
    input  wire logic                   link_sclk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   din_i,
    output logic [CSRC_SPAN_W-1:0]      span_word_o,
    output logic                        span_tgl_o,
    output logic [CSRC_CTL_W-1:0]       ctl_word_o,
    output logic                        ctl_tgl_o
);

    // ------------------------------------------------------------------
    // Bit positions inside the word seen at each commit edge
    // ------------------------------------------------------------------
    localparam int unsigned SO = CSRC_FRAME_BITS + 1 - CSRC_SPAN_EDGE;
    localparam int unsigned CO = CSRC_FRAME_BITS + 1 - CSRC_CTL_EDGE;

    logic [4:0]  edge_cnt_q;
    logic [14:0] shift_q;
    logic [15:0] frame_w;
    logic        frame_rst;
    logic        span_hit;
    logic        ctl_hit;

    // The frame signal ends a frame by clearing the edge count.
    assign frame_rst = sys_rst_i | cs_n_i;
    assign frame_w   = {shift_q, din_i};

    // Span frame: write 1, zero bit 0, register select 1.
    assign span_hit = (edge_cnt_q == 5'(CSRC_SPAN_EDGE - 1))
        && frame_w[CSRC_POS_WRITE - SO]
        && !frame_w[CSRC_POS_ZERO - SO]
        && frame_w[CSRC_POS_REGSEL - SO];
    // Control frame: write 1, zero bit 0, register select 0.
    assign ctl_hit = (edge_cnt_q == 5'(CSRC_CTL_EDGE - 1))
        && frame_w[CSRC_POS_WRITE - CO]
        && !frame_w[CSRC_POS_ZERO - CO]
        && !frame_w[CSRC_POS_REGSEL - CO];

    // Bits are sampled on falling edges; the count saturates at 16.
    always_ff @(negedge link_sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            edge_cnt_q <= 5'h00;
            shift_q    <= 15'h0000;
        end else begin
            shift_q <= frame_w[14:0];
            if (edge_cnt_q != 5'(CSRC_FRAME_BITS)) begin
                edge_cnt_q <= edge_cnt_q + 5'h01;
            end
        end
    end

    // Span commit on the eleventh edge, held until the next commit.
    always_ff @(negedge link_sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            span_word_o <= CSRC_SPAN_RST;
            span_tgl_o  <= 1'b0;
        end else if (span_hit) begin
            span_word_o <= frame_w[CSRC_POS_SPAN_TOP - SO :
                                   CSRC_POS_SPAN_BOT - SO];
            span_tgl_o  <= ~span_tgl_o;
        end
    end

    // Control commit on the fifteenth edge; bit 0 always stores 0.
    always_ff @(negedge link_sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctl_word_o <= CSRC_CTL_RST;
            ctl_tgl_o  <= 1'b0;
        end else if (ctl_hit) begin
            ctl_word_o <= {frame_w[CSRC_POS_CTL_TOP - CO :
                                   CSRC_POS_CTL_BOT - CO], 1'b0};
            ctl_tgl_o  <= ~ctl_tgl_o;
        end
    end

endmodule

`default_nettype wire

// >>> dv/csrc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------------
module csrc_host_model (
    output logic link_sclk_o,
    output logic cs_n_o,
    output logic din_o
);

    // The link clock idles high and runs only inside a frame.
    initial begin
        link_sclk_o = 1'h1;
        cs_n_o      = 1'h1;
        din_o       = 1'h1;
    end

    // Sends the top bits of a frame, MSB first, with a 48 ns link clock.
    // Data changes on the rising edge so it is steady at the falling one.
    task automatic send_frame(input logic [15:0] frame, input int nbits);
        #7;
        cs_n_o = 1'h0;
        for (int i = 15; i > 15 - nbits; i--) begin
            din_o = frame[i];
            #24 link_sclk_o = 1'h0;
            #24 link_sclk_o = 1'h1;
        end
        #24 cs_n_o = 1'h1;
        din_o = ~din_o; // Released line shows no stale bit.
        #200;
    endtask

endmodule

`default_nettype wire

// >>> dv/csrc_core_test.sv
`timescale 1ns/100ps
`default_nettype none

module csrc_core_test
    import csrc_pkg::*;
;
    logic                   ref_clk_i;
    logic                   sys_rst_i;
    logic                   ce_i;
    wire                    link_sclk;
    wire                    cs_n;
    wire                    din;
    logic                   conv_stb;
    csrc_conv_s             conv_cfg;
    csrc_conv_s             last_cfg;
    logic [CSRC_SPAN_W-1:0] span_cfg;
    csrc_span_e             ch0;
    csrc_span_e             ch1;
    logic [CSRC_CTL_W-1:0]  ctl;
    logic                   sel;
    logic                   seq_act;
    logic                   ref_int;
    logic                   ref_rdy;
    logic [1:0]             code;
    int                     bad_count = 0;
    int                     n_compared = 0;

    csrc_host_model csrc_host_model_inst (
        .link_sclk_o (link_sclk),
        .cs_n_o      (cs_n),
        .din_o       (din)
    );

    csrc_core #(
        .REF_SETTLE_CYC (40)
    ) csrc_core_inst (
        .ref_clk_i            (ref_clk_i),
        .sys_rst_i            (sys_rst_i),
        .ce_i                 (ce_i),
        .link_sclk_i          (link_sclk),
        .cs_n_i               (cs_n),
        .din_i                (din),
        .conv_stb_o           (conv_stb),
        .conv_cfg_o           (conv_cfg),
        .input_span_config_o  (span_cfg),
        .chan0_span_o         (ch0),
        .chan1_span_o         (ch1),
        .ctl_word_o           (ctl),
        .channel_select_bit_o (sel),
        .sequence_active_o    (seq_act),
        .ref_internal_o       (ref_int),
        .ref_ready_o          (ref_rdy)
    );

    // Free-running 25 MHz system clock.
    initial begin
        ref_clk_i = 1'h0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Keeps the configuration of the latest conversion start.
    always @(posedge ref_clk_i) begin
        if (conv_stb === 1'h1) begin
            last_cfg <= conv_cfg;
        end
    end

    // ------------------------------------------------------------------
    // Access and comparison tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One frame, then time for the commit to cross into the system domain.
    task automatic send(input logic [15:0] frame, input int nbits);
        csrc_host_model_inst.send_frame(frame, nbits);
        repeat (6) @(negedge ref_clk_i);
    endtask

    // A conversion frame with the data line low leaves the setup alone.
    task automatic conv(input logic chan, input logic [1:0] span);
        send(16'h0000, 16);
        check(last_cfg.chan, chan);
        check(last_cfg.span, span);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang is cut short long after the sequence should have ended.
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst_i = 1'h1;
        ce_i      = 1'h1;
        repeat (4) @(negedge ref_clk_i);
        sys_rst_i = 1'h0;
        repeat (2) @(negedge ref_clk_i);
        check(span_cfg, CSRC_SPAN_RST);
        check(ch1, CSRC_SPAN_PM10);
        check(ref_int, 1'h0);
        check(seq_act, 1'h0);
        // Every span code on channel 0, its complement on channel 1.
        for (int k = 0; k < 4; k++) begin
            code = 2'(k);
            send(16'hA000 | (16'(code) << 11)
                 | (16'(code ^ 2'h3) << 7), 16);
            check(span_cfg, {code, 2'h0, ~code});
            check(ch0, code);
            check(ch1, code ^ 2'h3);
        end
        send(16'h3980, 16);
        send(16'hF980, 16);
        send(16'hB980, 10);
        check(span_cfg, 6'h30);
        ce_i = 1'h0;
        send(16'hB080, 16);
        check(span_cfg, 6'h30);
        ce_i = 1'h1;
        repeat (6) @(negedge ref_clk_i);
        check(span_cfg, 6'h21);
        send(16'h8400, 16);
        check(ctl, 12'h400);
        check(sel, 1'h1);
        conv(1'h1, 2'h1);
        send(16'h840C, 16);
        check(seq_act, 1'h0);
        conv(1'h1, 2'h1);
        send(16'h8408, 16);
        check(seq_act, 1'h1);
        conv(1'h0, 2'h2);
        conv(1'h1, 2'h1);
        conv(1'h0, 2'h2);
        send(16'h8000, 16);
        check(seq_act, 1'h0);
        conv(1'h0, 2'h2);
        // The conversion during this write is not looked at.
        send(16'h8410, 16);
        check(ref_int, 1'h1);
        check(ref_rdy, 1'h0);
        // A conversion while the reference settles is flagged unusable.
        conv(1'h1, 2'h1);
        check(last_cfg.ref_int, 1'h1);
        check(last_cfg.ref_ok, 1'h0);
        repeat (20) @(negedge ref_clk_i);
        check(ref_rdy, 1'h1);
        conv(1'h1, 2'h1);
        check(last_cfg.ref_int, 1'h1);
        check(last_cfg.ref_ok, 1'h1);
        // A second reset mid-run brings every setting back to default.
        sys_rst_i = 1'h1;
        repeat (2) @(negedge ref_clk_i);
        sys_rst_i = 1'h0;
        repeat (2) @(negedge ref_clk_i);
        check(span_cfg, CSRC_SPAN_RST);
        check(ctl, CSRC_CTL_RST);
        check(seq_act, 1'h0);
        check(ref_rdy, 1'h0);
        conv(1'h0, 2'h0);
        check(last_cfg.ref_ok, 1'h1);
        print_verdict();
    end

endmodule

`default_nettype wire
